// File: core/nlse_pkg.sv
`default_nettype none
package nlse_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPA = 8'h04;
  localparam logic [7:0] OFS_OPB = 8'h08;
  localparam logic [7:0] OFS_PTR = 8'h0c;
  localparam logic [7:0] OFS_RES_LO = 8'h10;
  localparam logic [7:0] OFS_RES_HI = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_IMM32_BIT = 4;

  // Operation codes
  localparam logic [3:0] OP_MULX = 4'h0;
  localparam logic [3:0] OP_NEGD = 4'h1;
  localparam logic [3:0] OP_NEGS = 4'h2;
  localparam logic [3:0] OP_NEGW = 4'h3;
  localparam logic [3:0] OP_IDLE = 4'h4;
  localparam logic [3:0] OP_NOTQ = 4'h5;
  localparam logic [3:0] OP_NOTW = 4'h6;
  localparam logic [3:0] OP_ORI = 4'h7;
  localparam logic [3:0] OP_ORW = 4'h8;
  localparam logic [3:0] OP_PULL = 4'h9;
  localparam logic [3:0] OP_PLACE = 4'ha;

  // Flag bit positions in the flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_W = 4;

  // Status and interrupt bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAULT = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_W = 2;

  // Datapath constants
  localparam logic [31:0] SIGN_BIT32 = 32'h8000_0000;
  localparam logic [31:0] MOST_NEG32 = 32'h8000_0000;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam int QUICK_W = 4;
  localparam int IMM16_W = 16;

endpackage : nlse_pkg
`default_nettype wire

// File: core/nlse_core.sv
// Operation
// RULE_01 - Signed multiply of two words writes the full 64-bit product to the pair.
// RULE_02 - Widening multiply sets V when product exceeds one word; clears N, Z, C.
// RULE_03 - Double negate copies source with only the sign bit flipped, no trap.
// RULE_04 - Double negate of zeros and NaNs only flips the sign bit.
// RULE_05 - Single negate flips the sign bit only, zeros and NaNs included, no trap.
// RULE_06 - Word negate stores minus source; N is bit 31, Z zero, C nonzero source.
// RULE_07 - Word negate sets V exactly for the most negative source value.
// RULE_08 - Idle changes nothing and ignores its byte operand.
// RULE_09 - Quick invert zero-extends 4 bits, inverts; N set, Z V C cleared.
// RULE_10 - Word invert writes inverse; N is bit 31, Z on zero, V C cleared.
// RULE_11 - Immediate OR sign-extends a 16-bit immediate; 32-bit form used otherwise.
// RULE_12 - Register OR writes OR of both; both OR forms set N, Z, clear V, C.
// RULE_13 - Stack pull reads word at pointer into destination and adds 4.
// RULE_14 - On a pull fault the pointer stays incremented.
// RULE_15 - Stack place subtracts 4 first, then stores at the new pointer.
// RULE_16 - On a place fault the pointer stays decremented.
// RULE_17 - Float negates, idle, pull and place leave the flags unchanged.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module nlse_core #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Stack memory port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic mem_fault_i,
  input wire logic [31:0] mem_rdata_i,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef enum logic [1:0] {
    NLSE_IDLE,
    NLSE_EXEC,
    NLSE_MEM
  } nlse_state_t;

  nlse_state_t state_reg;
  logic [3:0] op_reg;
  logic imm32_reg;
  logic [31:0] opa_reg;
  logic [31:0] opb_reg;
  logic [31:0] ptr_reg;
  logic [31:0] res_lo_reg;
  logic [31:0] res_hi_reg;
  logic [nlse_pkg::FLAG_W-1:0] flags_reg;
  logic [nlse_pkg::FLAG_W-1:0] flags_next;
  logic fault_reg;
  logic [nlse_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [nlse_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [nlse_pkg::IRQ_W-1:0] irq_set;
  logic [31:0] prdata_reg;
  logic mem_we_reg;
  logic [31:0] mem_addr_reg;
  logic [31:0] mem_wdata_reg;

  logic [ADDR_W-1:0] ofs;
  logic setup_rd;
  logic acc;
  logic wr_en;
  logic mapped;
  logic busy;
  logic start;
  logic exec_now;
  logic mem_done;
  logic mem_flt;
  logic [31:0] rd_mux;

  logic [63:0] prod;
  logic [31:0] src_ext;
  logic [31:0] res_lo_next;
  logic [31:0] res_hi_next;
  logic writes_res;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign ofs = paddr_i;
  assign setup_rd = psel_i && !penable_i && !pwrite_i;
  assign acc = psel_i && penable_i;
  assign wr_en = acc && pwrite_i && mapped;
  assign busy = (state_reg != NLSE_IDLE);
  assign start = wr_en && !busy && (ofs == ADDR_W'(nlse_pkg::OFS_CMD));
  assign exec_now = (state_reg == NLSE_EXEC);
  assign mem_done = (state_reg == NLSE_MEM) && mem_ack_i && !mem_fault_i;
  assign mem_flt = (state_reg == NLSE_MEM) && mem_fault_i;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (ofs)
      ADDR_W'(nlse_pkg::OFS_CMD): begin
        rd_mux[nlse_pkg::CMD_OP_LSB +: nlse_pkg::CMD_OP_W] = op_reg;
        rd_mux[nlse_pkg::CMD_IMM32_BIT] = imm32_reg;
      end
      ADDR_W'(nlse_pkg::OFS_OPA): rd_mux = opa_reg;
      ADDR_W'(nlse_pkg::OFS_OPB): rd_mux = opb_reg;
      ADDR_W'(nlse_pkg::OFS_PTR): rd_mux = ptr_reg;
      ADDR_W'(nlse_pkg::OFS_RES_LO): rd_mux = res_lo_reg;
      ADDR_W'(nlse_pkg::OFS_RES_HI): rd_mux = res_hi_reg;
      ADDR_W'(nlse_pkg::OFS_FLAGS): rd_mux[nlse_pkg::FLAG_W-1:0] = flags_reg;
      ADDR_W'(nlse_pkg::OFS_STATUS): begin
        rd_mux[nlse_pkg::STAT_BUSY] = busy;
        rd_mux[nlse_pkg::STAT_FAULT] = fault_reg;
      end
      ADDR_W'(nlse_pkg::OFS_IRQ_STAT): rd_mux[nlse_pkg::IRQ_W-1:0] = irq_stat_reg;
      ADDR_W'(nlse_pkg::OFS_IRQ_MASK): rd_mux[nlse_pkg::IRQ_W-1:0] = irq_mask_reg;
      default: mapped = 1'b0;
    endcase
  end

  // Read data latched at the setup edge; no wait state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = acc;
  assign pslverr_o = acc && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Command and operand registers

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_reg <= nlse_pkg::OP_IDLE;
      imm32_reg <= 1'b0;
    end else if (start) begin
      op_reg <= pwdata_i[nlse_pkg::CMD_OP_LSB +: nlse_pkg::CMD_OP_W];
      imm32_reg <= pwdata_i[nlse_pkg::CMD_IMM32_BIT];
    end
  end

  // Operands are frozen while a command runs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      opa_reg <= 32'h0000_0000;
      opb_reg <= 32'h0000_0000;
    end else if (wr_en && !busy) begin
      if (ofs == ADDR_W'(nlse_pkg::OFS_OPA)) begin
        opa_reg <= pwdata_i;
      end
      if (ofs == ADDR_W'(nlse_pkg::OFS_OPB)) begin
        opb_reg <= pwdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= NLSE_IDLE;
    end else begin
      case (state_reg)
        NLSE_IDLE: begin
          if (start) begin
            state_reg <= NLSE_EXEC;
          end
        end
        // Stack ops go on to wait for the memory answer
        NLSE_EXEC: begin
          if (op_reg == nlse_pkg::OP_PULL || op_reg == nlse_pkg::OP_PLACE) begin
            state_reg <= NLSE_MEM;
          end else begin
            state_reg <= NLSE_IDLE;
          end
        end
        NLSE_MEM: begin
          if (mem_done || mem_flt) begin
            state_reg <= NLSE_IDLE;
          end
        end
        default: state_reg <= NLSE_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  assign prod = $signed(opa_reg) * $signed(opb_reg); // see RULE_01

  // Immediate: 16-bit form sign-extended, otherwise the whole word
  assign src_ext = imm32_reg ? opa_reg :
    {{(32 - nlse_pkg::IMM16_W){opa_reg[nlse_pkg::IMM16_W-1]}},
     opa_reg[nlse_pkg::IMM16_W-1:0]}; // see RULE_11

  // Results and flags for the op held in op_reg
  always_comb begin
    res_lo_next = res_lo_reg;
    res_hi_next = res_hi_reg;
    writes_res = 1'b1;
    flags_next = flags_reg; // see RULE_17
    case (op_reg)
      nlse_pkg::OP_MULX: begin
        res_lo_next = prod[31:0]; // see RULE_01
        res_hi_next = prod[63:32];
        // V when the high word is not the sign copy of the low word
        flags_next = '0; // see RULE_02
        flags_next[nlse_pkg::FLAG_V] = (prod[63:32] != {32{prod[31]}}); // see RULE_02
      end
      nlse_pkg::OP_NEGD: begin
        // Low word in opa, high word with sign in opb; no arithmetic
        res_lo_next = opa_reg; // see RULE_03
        res_hi_next = opb_reg ^ nlse_pkg::SIGN_BIT32; // see RULE_04
      end
      nlse_pkg::OP_NEGS: begin
        res_lo_next = opa_reg ^ nlse_pkg::SIGN_BIT32; // see RULE_05
      end
      nlse_pkg::OP_NEGW: begin
        res_lo_next = 32'h0000_0000 - opa_reg; // see RULE_06
        flags_next[nlse_pkg::FLAG_N] = res_lo_next[31];
        flags_next[nlse_pkg::FLAG_Z] = (res_lo_next == 32'h0000_0000);
        flags_next[nlse_pkg::FLAG_C] = (opa_reg != 32'h0000_0000); // see RULE_06
        flags_next[nlse_pkg::FLAG_V] = (opa_reg == nlse_pkg::MOST_NEG32); // see RULE_07
      end
      nlse_pkg::OP_NOTQ: begin
        res_lo_next = ~{{(32 - nlse_pkg::QUICK_W){1'b0}},
                        opa_reg[nlse_pkg::QUICK_W-1:0]}; // see RULE_09
        flags_next = '0;
        flags_next[nlse_pkg::FLAG_N] = 1'b1; // see RULE_09
      end
      nlse_pkg::OP_NOTW: begin
        res_lo_next = ~opa_reg; // see RULE_10
        flags_next = '0;
        flags_next[nlse_pkg::FLAG_N] = res_lo_next[31];
        flags_next[nlse_pkg::FLAG_Z] = (res_lo_next == 32'h0000_0000); // see RULE_10
      end
      nlse_pkg::OP_ORI, nlse_pkg::OP_ORW: begin
        if (op_reg == nlse_pkg::OP_ORI) begin
          res_lo_next = opb_reg | src_ext; // see RULE_11
        end else begin
          res_lo_next = opb_reg | opa_reg; // see RULE_12
        end
        flags_next = '0;
        flags_next[nlse_pkg::FLAG_N] = res_lo_next[31];
        flags_next[nlse_pkg::FLAG_Z] = (res_lo_next == 32'h0000_0000); // see RULE_12
      end
      default: begin
        // Idle, pull and place: nothing here; byte operand ignored
        writes_res = 1'b0; // see RULE_08
      end
    endcase
  end

  // Register ops load at execute; a pull loads on the memory answer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      res_lo_reg <= 32'h0000_0000;
      res_hi_reg <= 32'h0000_0000;
    end else if (exec_now && writes_res) begin
      res_lo_reg <= res_lo_next;
      res_hi_reg <= res_hi_next;
    end else if (mem_done && op_reg == nlse_pkg::OP_PULL) begin
      res_lo_reg <= mem_rdata_i; // see RULE_13
    end
  end

  // Software may preset the flags while idle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flags_reg <= '0;
    end else if (exec_now) begin
      flags_reg <= flags_next; // see RULE_17
    end else if (wr_en && !busy && ofs == ADDR_W'(nlse_pkg::OFS_FLAGS)) begin
      flags_reg <= pwdata_i[nlse_pkg::FLAG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer and memory port

  // Pointer moves before the access, so a fault leaves it moved
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ptr_reg <= 32'h0000_0000;
    end else if (exec_now && op_reg == nlse_pkg::OP_PULL) begin
      ptr_reg <= ptr_reg + nlse_pkg::STACK_STEP; // see RULE_13, RULE_14
    end else if (exec_now && op_reg == nlse_pkg::OP_PLACE) begin
      ptr_reg <= ptr_reg - nlse_pkg::STACK_STEP; // see RULE_15, RULE_16
    end else if (wr_en && !busy && ofs == ADDR_W'(nlse_pkg::OFS_PTR)) begin
      ptr_reg <= pwdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 32'h0000_0000;
      mem_wdata_reg <= 32'h0000_0000;
    end else if (exec_now && op_reg == nlse_pkg::OP_PULL) begin
      mem_we_reg <= 1'b0;
      mem_addr_reg <= ptr_reg; // see RULE_13
    end else if (exec_now && op_reg == nlse_pkg::OP_PLACE) begin
      mem_we_reg <= 1'b1;
      mem_addr_reg <= ptr_reg - nlse_pkg::STACK_STEP; // see RULE_15
      mem_wdata_reg <= opa_reg;
    end
  end

  // Request stays up until ack or fault
  assign mem_req_o = (state_reg == NLSE_MEM);
  assign mem_we_o = mem_we_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;

  // Last command faulted; cleared by the next start
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
    end else if (mem_flt) begin
      fault_reg <= 1'b1; // see RULE_14, RULE_16
    end else if (start) begin
      fault_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Done at execute for register ops, on the answer for stack ops
  assign irq_set[nlse_pkg::IRQ_DONE] = (exec_now && !(op_reg == nlse_pkg::OP_PULL ||
    op_reg == nlse_pkg::OP_PLACE)) || mem_done;
  assign irq_set[nlse_pkg::IRQ_FAULT] = mem_flt;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else if (wr_en && ofs == ADDR_W'(nlse_pkg::OFS_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata_i[nlse_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_mask_reg <= '0;
    end else if (wr_en && ofs == ADDR_W'(nlse_pkg::OFS_IRQ_MASK)) begin
      irq_mask_reg <= pwdata_i[nlse_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

endmodule : nlse_core
`default_nettype wire

// File: bench/nlse_properties.sv
`timescale 1ns/1ps
`default_nettype none
module nlse_properties (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Stack memory
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic mem_fault_i
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  property p_ready;
    pready_o == (psel_i && penable_i);
  endproperty
  a_ready: assert property (p_ready) else $error("pready wrong");
  property p_err;
    pslverr_o |-> psel_i && penable_i;
  endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  property p_rdata;
    !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o);
  endproperty
  a_rdata: assert property (p_rdata) else $error("prdata moved");
  property p_hold;
    mem_req_o && !mem_ack_i && !mem_fault_i |=> mem_req_o;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_drop;
    mem_req_o && (mem_ack_i || mem_fault_i) |=> !mem_req_o;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept");
  property p_addr;
    mem_req_o && !mem_ack_i && !mem_fault_i |=> $stable(mem_addr_o) && $stable(mem_we_o);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_wdata;
    mem_req_o && mem_we_o && !mem_ack_i && !mem_fault_i |=> $stable(mem_wdata_o);
  endproperty
  a_wdata: assert property (p_wdata) else $error("store data moved");
  property p_gap;
    $fell(mem_req_o) |-> !mem_req_o [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("request repeated");
endmodule : nlse_properties

bind nlse_core nlse_properties u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
  .mem_fault_i(mem_fault_i));
`default_nettype wire

// File: bench/nlse_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module nlse_mem_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Memory port
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic mem_fault_o,
  output logic [31:0] mem_rdata_o,
  // Behaviour
  input wire logic [1:0] lat_i,
  input wire logic fault_en_i
);
  logic [31:0] mem_reg [16];
  logic [1:0] wait_reg;
  logic hit;
  assign hit = mem_req_i && !mem_ack_o && !mem_fault_o && wait_reg == lat_i;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      mem_fault_o <= 1'b0;
      wait_reg <= 2'h0;
    end else begin
      mem_ack_o <= hit && !fault_en_i;
      mem_fault_o <= hit && fault_en_i;
      if (hit) begin
        wait_reg <= 2'h0;
      end else if (mem_req_i && !mem_ack_o && !mem_fault_o) begin
        wait_reg <= wait_reg + 2'h1;
      end
      if (hit && mem_we_i && !fault_en_i) begin
        mem_reg[mem_addr_i[5:2]] <= mem_wdata_i;
      end
    end
  end
  // Read data only valid with ack
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_rdata_o <= 32'h5a5aa5a5;
    end else if (hit && !mem_we_i) begin
      mem_rdata_o <= mem_reg[mem_addr_i[5:2]];
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule : nlse_mem_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, ack_addr, q;
  logic pready_o, pslverr_o, mem_req_o, mem_we_o, mem_ack_i, mem_fault_i, irq_o, perr;
  logic [1:0] lat = 2'h0;
  logic fault_en = 1'b0;
  int err_count = 0;
  int samples_checked = 0;

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  nlse_core dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_fault_i(mem_fault_i), .mem_rdata_i(mem_rdata_i), .irq_o(irq_o));
  nlse_mem_model u_mem (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_ack_o(mem_ack_i), .mem_fault_o(mem_fault_i), .mem_rdata_o(mem_rdata_i),
    .lat_i(lat), .fault_en_i(fault_en));

  always @(posedge clk_sys_i) begin
    if (mem_ack_i === 1'b1) ack_addr <= mem_addr_o;
  end

  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic fail_to(input string nm);
    err_count++;
    $display("MISMATCH %s exp done got hang", nm);
    end_of_test();
  endtask : fail_to

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) fail_to("pready");
    q = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic do_op(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b);
    int n;
    n = 0;
    wr(nlse_pkg::OFS_OPA, a);
    wr(nlse_pkg::OFS_OPB, b);
    wr(nlse_pkg::OFS_CMD, c);
    rd(nlse_pkg::OFS_STATUS);
    while (q[nlse_pkg::STAT_BUSY] !== 1'b0 && n < 30) begin
      rd(nlse_pkg::OFS_STATUS);
      n++;
    end
    if (q[nlse_pkg::STAT_BUSY] !== 1'b0) fail_to("busy");
  endtask : do_op

  // Preset flags, run one op, compare result word and flags
  task automatic op_chk(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] fp, input logic [31:0] elo, input logic [31:0] ef);
    wr(nlse_pkg::OFS_FLAGS, fp);
    do_op({28'h0, op}, a, b);
    rd(nlse_pkg::OFS_RES_LO);
    chk("res_lo", elo, q);
    rd(nlse_pkg::OFS_FLAGS);
    chk("flags", ef, q);
  endtask : op_chk

  task automatic hi_chk(input logic [31:0] e);
    rd(nlse_pkg::OFS_RES_HI);
    chk("res_hi", e, q);
  endtask : hi_chk

  ////////////////////////////////////////////////////////////////
  task automatic t_arith();
    rd(nlse_pkg::OFS_CMD);
    chk("cmd", 32'h4, q);
    op_chk(nlse_pkg::OP_MULX, 32'h80000000, 32'h1, 32'hd, 32'h80000000, 32'h0);
    hi_chk(32'hffffffff);
    op_chk(nlse_pkg::OP_MULX, 32'h80000000, 32'hffffffff, 32'hd, 32'h80000000, 32'h2);
    hi_chk(32'h0);
    op_chk(nlse_pkg::OP_NEGD, 32'h0, 32'h0, 32'h5, 32'h0, 32'h5);
    hi_chk(32'h80000000);
    op_chk(nlse_pkg::OP_NEGD, 32'h1, 32'hfff80000, 32'ha, 32'h1, 32'ha);
    hi_chk(32'h7ff80000);
    op_chk(nlse_pkg::OP_NEGS, 32'h80000000, 32'h0, 32'h5, 32'h0, 32'h5);
    op_chk(nlse_pkg::OP_NEGS, 32'h7fc00001, 32'h0, 32'h0, 32'hffc00001, 32'h0);
    op_chk(nlse_pkg::OP_NEGW, 32'h0, 32'h0, 32'hb, 32'h0, 32'h4);
    op_chk(nlse_pkg::OP_NEGW, 32'h5, 32'h0, 32'h0, 32'hfffffffb, 32'h9);
    op_chk(nlse_pkg::OP_NEGW, 32'h80000000, 32'h0, 32'h0, 32'h80000000, 32'hb);
  endtask : t_arith

  task automatic t_idle();
    wr(nlse_pkg::OFS_FLAGS, 32'ha);
    do_op(32'h0000ab04, 32'h1, 32'h2);
    rd(nlse_pkg::OFS_RES_LO);
    chk("res_lo", 32'h80000000, q);
    hi_chk(32'h7ff80000);
    rd(nlse_pkg::OFS_PTR);
    chk("ptr", 32'h0, q);
    rd(nlse_pkg::OFS_FLAGS);
    chk("flags", 32'ha, q);
  endtask : t_idle

  task automatic t_logic();
    op_chk(nlse_pkg::OP_NOTQ, 32'h4, 32'h0, 32'h7, 32'hfffffffb, 32'h8);
    op_chk(nlse_pkg::OP_NOTQ, 32'hfffffff0, 32'h0, 32'h0, 32'hffffffff, 32'h8);
    op_chk(nlse_pkg::OP_NOTW, 32'hffffffff, 32'h0, 32'h3, 32'h0, 32'h4);
    op_chk(nlse_pkg::OP_NOTW, 32'h0, 32'h0, 32'h3, 32'hffffffff, 32'h8);
    op_chk(nlse_pkg::OP_ORI, 32'h8000, 32'h00ff00ff, 32'h3, 32'hffff80ff, 32'h8);
    do_op({27'h0, 1'b1, nlse_pkg::OP_ORI}, 32'h8000, 32'h00ff00ff);
    rd(nlse_pkg::OFS_RES_LO);
    chk("res_lo", 32'h00ff80ff, q);
    op_chk(nlse_pkg::OP_ORW, 32'h001100ff, 32'h7770088f, 32'h3, 32'h777108ff, 32'h0);
    op_chk(nlse_pkg::OP_ORW, 32'h0, 32'h0, 32'h3, 32'h0, 32'h4);
  endtask : t_logic

  task automatic t_stack();
    wr(nlse_pkg::OFS_PTR, 32'h40);
    lat <= 2'h2;
    op_chk(nlse_pkg::OP_PLACE, 32'hcafe0001, 32'h0, 32'h6, 32'h0, 32'h6);
    rd(nlse_pkg::OFS_PTR);
    chk("ptr", 32'h3c, q);
    chk("addr", 32'h3c, ack_addr);
    lat <= 2'h0;
    op_chk(nlse_pkg::OP_PULL, 32'h0, 32'h0, 32'h6, 32'hcafe0001, 32'h6);
    rd(nlse_pkg::OFS_PTR);
    chk("ptr", 32'h40, q);
    chk("addr", 32'h3c, ack_addr);
    fault_en <= 1'b1;
    op_chk(nlse_pkg::OP_PULL, 32'h0, 32'h0, 32'h0, 32'hcafe0001, 32'h0);
    rd(nlse_pkg::OFS_PTR);
    chk("ptr", 32'h44, q);
    rd(nlse_pkg::OFS_STATUS);
    chk("status", 32'h2, q);
    op_chk(nlse_pkg::OP_PLACE, 32'h1, 32'h0, 32'h0, 32'hcafe0001, 32'h0);
    rd(nlse_pkg::OFS_PTR);
    chk("ptr", 32'h40, q);
    fault_en <= 1'b0;
  endtask : t_stack

  task automatic t_irq();
    rd(nlse_pkg::OFS_IRQ_STAT);
    chk("irq_stat", 32'h3, q);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(nlse_pkg::OFS_IRQ_MASK, 32'h2);
    @(negedge clk_sys_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(nlse_pkg::OFS_IRQ_STAT, 32'h2);
    @(negedge clk_sys_i);
    chk("irq", 32'h0, {31'h0, irq_o});
    rd(8'h30);
    chk("unmapped", 32'h0, q);
    chk("pslverr", 32'h1, {31'h0, perr});
  endtask : t_irq

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_arith();
    t_idle();
    t_logic();
    t_stack();
    t_irq();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
